// ---- verilog/host_bus_pkg.sv ----
package host_bus_pkg;
  // bus width codes reported on BUS_WIDTH_O
  localparam logic [1:0] WIDTH_8       = 2'h0;
  localparam logic [1:0] WIDTH_16      = 2'h1;
  localparam logic [1:0] WIDTH_32      = 2'h2;
  // width used when the serial rom owns the strap pin, unless the 32-bit variant is set
  localparam logic [1:0] WIDTH_ROM_DEF = 2'h1;
  // address field bounds
  localparam int ADDR_MSB   = 15;
  localparam int ADDR_LSB   = 1;
  localparam int DECODE_LSB = 4;
  // reset values
  localparam logic       QUAL_N_RESET = 1'h1;
  localparam logic       SYNC_RESET   = 1'h1;
  // strap sampler states
  typedef enum logic [1:0] {
    ST_STRAP = 2'h1,
    ST_RUN   = 2'h2
  } strap_state_t;
endpackage

// ---- verilog/addr_latch_reg.sv ----
module addr_latch_reg (
  input  wire logic                                                   clk_i,
  input  wire logic                                                   rst_n_i,
  input  wire logic                                                   capture_i,
  input  wire logic [host_bus_pkg::ADDR_MSB:host_bus_pkg::ADDR_LSB]   addr_i,
  input  wire logic                                                   qual_n_i,
  output logic      [host_bus_pkg::ADDR_MSB:host_bus_pkg::ADDR_LSB]   addr_o,
  output logic                                                        qual_n_o
);
  // holds address and qualifier taken at the strobe edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_o   <= '0;
      qual_n_o <= host_bus_pkg::QUAL_N_RESET;
    end else if (capture_i) begin
      addr_o   <= addr_i;
      qual_n_o <= qual_n_i;
    end
  end
endmodule // addr_latch_reg

// ---- verilog/host_bus_strobe_decode.sv ----
module host_bus_strobe_decode (
  input  wire logic                                                   CLK_I,
  input  wire logic                                                   RST_N_I,
  input  wire logic                                                   SYNC_WRITE_READ_SEL_I,
  input  wire logic                                                   SYNC_CYCLE_I,
  input  wire logic                                                   ADDR_QUALIFIER_N_I,
  input  wire logic                                                   WRITE_STROBE_N_I,
  input  wire logic                                                   READ_STROBE_N_I,
  input  wire logic                                                   ADDR_LATCH_STROBE_N_I,
  input  wire logic [host_bus_pkg::ADDR_MSB:host_bus_pkg::ADDR_LSB]   ADDR_I,
  input  wire logic [host_bus_pkg::ADDR_MSB:host_bus_pkg::DECODE_LSB] BASE_ADDR_I,
  input  wire logic                                                   SERIAL_ROM_DATA_IN_I,
  input  wire logic                                                   SERIAL_ROM_ENABLE_STRAP_I,
  input  wire logic                                                   SYNC_MODE_STRAP_N_I,
  input  wire logic                                                   BUS32_VARIANT_I,
  output logic                                                        WRITE_ACCESS_O,
  output logic                                                        READ_ACCESS_O,
  output logic                                                        LOCAL_SELECT_N_O,
  output logic      [host_bus_pkg::ADDR_MSB:host_bus_pkg::ADDR_LSB]   LATCHED_ADDR_O,
  output logic                                                        LATCHED_QUAL_N_O,
  output logic      [1:0]                                             BUS_WIDTH_O,
  output logic                                                        SYNC_MODE_O,
  output logic                                                        ROM_SERIAL_DATA_O
);

  host_bus_pkg::strap_state_t state;
  logic                       prev_latch_strobe_n;
  logic                       latch_rise;
  logic                       next_write;
  logic                       next_read;
  logic                       next_select_n;
  logic [1:0]                 next_width;

  function automatic logic addr_match(input logic [host_bus_pkg::ADDR_MSB:host_bus_pkg::ADDR_LSB] a,
                                      input logic [host_bus_pkg::ADDR_MSB:host_bus_pkg::DECODE_LSB] b);
    addr_match = (a[host_bus_pkg::ADDR_MSB:host_bus_pkg::DECODE_LSB] == b);
  endfunction

  // strap sampler: one capture cycle after reset release
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state <= host_bus_pkg::ST_STRAP;
    end else begin
      case (state)
        host_bus_pkg::ST_STRAP: state <= host_bus_pkg::ST_RUN;
        host_bus_pkg::ST_RUN:   state <= host_bus_pkg::ST_RUN;
        default:                state <= host_bus_pkg::ST_STRAP;
      endcase
    end
  end

  always_comb begin
    if (BUS32_VARIANT_I) begin
      next_width = host_bus_pkg::WIDTH_32;
    end else if (SERIAL_ROM_ENABLE_STRAP_I) begin
      next_width = host_bus_pkg::WIDTH_ROM_DEF;
    end else if (SERIAL_ROM_DATA_IN_I) begin
      next_width = host_bus_pkg::WIDTH_16;
    end else begin
      next_width = host_bus_pkg::WIDTH_8;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      BUS_WIDTH_O <= host_bus_pkg::WIDTH_8;
      SYNC_MODE_O <= host_bus_pkg::SYNC_RESET;
    end else if (state == host_bus_pkg::ST_STRAP) begin
      BUS_WIDTH_O <= next_width;
      SYNC_MODE_O <= !SYNC_MODE_STRAP_N_I;
    end
  end

  // rom data path only while rom owns the pin
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ROM_SERIAL_DATA_O <= 1'h0;
    end else begin
      ROM_SERIAL_DATA_O <= SERIAL_ROM_ENABLE_STRAP_I & SERIAL_ROM_DATA_IN_I;
    end
  end

  // access decode
  always_comb begin
    next_write    = 1'h0;
    next_read     = 1'h0;
    next_select_n = !(!ADDR_QUALIFIER_N_I && addr_match(ADDR_I, BASE_ADDR_I));
    if (!ADDR_QUALIFIER_N_I && state == host_bus_pkg::ST_RUN) begin
      if (SYNC_MODE_O) begin
        next_write = SYNC_CYCLE_I & SYNC_WRITE_READ_SEL_I;
        next_read  = SYNC_CYCLE_I & !SYNC_WRITE_READ_SEL_I;
      end else begin
        next_write = !WRITE_STROBE_N_I;
        next_read  = !READ_STROBE_N_I;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      WRITE_ACCESS_O   <= 1'h0;
      READ_ACCESS_O    <= 1'h0;
      LOCAL_SELECT_N_O <= 1'h1;
    end else begin
      WRITE_ACCESS_O   <= next_write;
      READ_ACCESS_O    <= next_read;
      LOCAL_SELECT_N_O <= next_select_n;
    end
  end

  // edge detector on the latch strobe
  always_ff @(posedge CLK_I) begin
    prev_latch_strobe_n <= ADDR_LATCH_STROBE_N_I;
  end

  assign latch_rise = !prev_latch_strobe_n & ADDR_LATCH_STROBE_N_I;

  addr_latch_reg u_latch (
    .clk_i     (CLK_I),
    .rst_n_i   (RST_N_I),
    .capture_i (latch_rise),
    .addr_i    (ADDR_I),
    .qual_n_i  (ADDR_QUALIFIER_N_I),
    .addr_o    (LATCHED_ADDR_O),
    .qual_n_o  (LATCHED_QUAL_N_O)
  );

  chk_sync_write_sel: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_RUN && SYNC_MODE_O && !ADDR_QUALIFIER_N_I && SYNC_CYCLE_I && SYNC_WRITE_READ_SEL_I)
    |=> (WRITE_ACCESS_O && !READ_ACCESS_O))
    else $error("sync write not decoded");

  chk_sync_read_sel: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_RUN && SYNC_MODE_O && !ADDR_QUALIFIER_N_I && SYNC_CYCLE_I && !SYNC_WRITE_READ_SEL_I)
    |=> (READ_ACCESS_O && !WRITE_ACCESS_O))
    else $error("sync read not decoded");

  chk_qual_blocks_access: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ADDR_QUALIFIER_N_I |=> (!WRITE_ACCESS_O && !READ_ACCESS_O && LOCAL_SELECT_N_O))
    else $error("access decoded with qualifier high");

  chk_async_write_strobe: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_RUN && !SYNC_MODE_O && !ADDR_QUALIFIER_N_I)
    |=> (WRITE_ACCESS_O == !$past(WRITE_STROBE_N_I)))
    else $error("async write strobe not followed");

  chk_latch_capture: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $rose(ADDR_LATCH_STROBE_N_I)
    |=> (LATCHED_ADDR_O == $past(ADDR_I) && LATCHED_QUAL_N_O == $past(ADDR_QUALIFIER_N_I)))
    else $error("address not latched at strobe rise");

  chk_width_strap: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_STRAP && !SERIAL_ROM_ENABLE_STRAP_I && !BUS32_VARIANT_I)
    |=> (BUS_WIDTH_O == ($past(SERIAL_ROM_DATA_IN_I) ? host_bus_pkg::WIDTH_16 : host_bus_pkg::WIDTH_8)))
    else $error("bus width strap misread");

  chk_rom_owns_pin: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_STRAP && SERIAL_ROM_ENABLE_STRAP_I && !BUS32_VARIANT_I)
    |=> (BUS_WIDTH_O == host_bus_pkg::WIDTH_ROM_DEF && ROM_SERIAL_DATA_O == $past(SERIAL_ROM_DATA_IN_I)))
    else $error("rom data pin used as width strap");

  chk_async_read_strobe: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_RUN && !SYNC_MODE_O && !ADDR_QUALIFIER_N_I && !READ_STROBE_N_I)
    |=> READ_ACCESS_O)
    else $error("async read strobe not followed");

  chk_sync_mode_strap: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_STRAP) |=> (SYNC_MODE_O == !$past(SYNC_MODE_STRAP_N_I)))
    else $error("sync mode strap misread");

  chk_local_select: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    1'b1 |=> (LOCAL_SELECT_N_O == !(!$past(ADDR_QUALIFIER_N_I)
      && $past(ADDR_I[host_bus_pkg::ADDR_MSB:host_bus_pkg::DECODE_LSB]) == $past(BASE_ADDR_I))))
    else $error("local select decode wrong");

  chk_strap_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_RUN) |=> ($stable(BUS_WIDTH_O) && $stable(SYNC_MODE_O)))
    else $error("strap value changed after sampling");

  chk_reset_outputs: assert property (@(posedge CLK_I)
    !RST_N_I |=> (!WRITE_ACCESS_O && !READ_ACCESS_O && LOCAL_SELECT_N_O && !ROM_SERIAL_DATA_O
      && BUS_WIDTH_O == host_bus_pkg::WIDTH_8 && SYNC_MODE_O == host_bus_pkg::SYNC_RESET
      && LATCHED_QUAL_N_O == host_bus_pkg::QUAL_N_RESET && LATCHED_ADDR_O == '0))
    else $error("outputs not at reset values");

  chk_sync_cycle_gate: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (SYNC_MODE_O && !SYNC_CYCLE_I) |=> (!WRITE_ACCESS_O && !READ_ACCESS_O))
    else $error("sync access without cycle qualifier");

  chk_async_idle_strobes: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!SYNC_MODE_O && WRITE_STROBE_N_I && READ_STROBE_N_I) |=> (!WRITE_ACCESS_O && !READ_ACCESS_O))
    else $error("async access without strobe");

  chk_latch_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !$rose(ADDR_LATCH_STROBE_N_I) |=> ($stable(LATCHED_ADDR_O) && $stable(LATCHED_QUAL_N_O)))
    else $error("latched address moved without strobe rise");

  chk_width_32: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_STRAP && BUS32_VARIANT_I) |=> (BUS_WIDTH_O == host_bus_pkg::WIDTH_32))
    else $error("32-bit variant width wrong");

  chk_rom_data_gate: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !SERIAL_ROM_ENABLE_STRAP_I |=> !ROM_SERIAL_DATA_O)
    else $error("rom data passed while rom disabled");

  chk_async_read_level: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state == host_bus_pkg::ST_RUN && !SYNC_MODE_O && !ADDR_QUALIFIER_N_I)
    |=> (READ_ACCESS_O == !$past(READ_STROBE_N_I)))
    else $error("async read strobe level not followed");

endmodule // host_bus_strobe_decode

// ---- tb/host_cpu_model.sv ----
module host_cpu_model (
  input  wire logic        clk_i,
  output logic             sel_o,
  output logic             cyc_o,
  output logic             qual_n_o,
  output logic             wr_n_o,
  output logic             rd_n_o,
  output logic             ads_n_o,
  output logic [15:1]      addr_o,
  output logic             din_o,
  output logic             rom_en_o,
  output logic             sync_n_o,
  output logic             b32_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {sel_o, cyc_o, addr_o} = 17'h0;
    {qual_n_o, wr_n_o, rd_n_o, ads_n_o} = 4'hf;
    {din_o, rom_en_o, sync_n_o, b32_o} = 4'h0;
  end
  // board straps, set while reset is held
  task strap(input logic sn, re, d, b);
    {sync_n_o, rom_en_o, din_o, b32_o} = {sn, re, d, b};
  endtask
  // one bus cycle of select, qualifier, strobes and address
  task drive(input logic s, c, q, w, r, input logic [15:1] a);
    @(negedge clk_i);
    {sel_o, cyc_o, qual_n_o, wr_n_o, rd_n_o, addr_o} = {s, c, q, w, r, a};
  endtask
  // latch strobe low, then rise with address and qualifier valid
  task latch(input logic [15:1] a, input logic q);
    @(negedge clk_i);
    ads_n_o = 1'h0;
    @(negedge clk_i);
    {ads_n_o, addr_o, qual_n_o} = {1'h1, a, q};
    @(negedge clk_i);
    {addr_o, qual_n_o} = {~a, ~q};
  endtask
endmodule // host_cpu_model

// ---- tb/host_bus_strobe_decode_bench.sv ----
module host_bus_strobe_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [26:0] row_t;
  localparam logic [15:4] BASE = 12'h5a3;
  localparam logic [15:1] HIT  = {BASE, 3'h6};
  localparam logic [15:1] MISS = {BASE ^ 12'h010, 3'h6};
  // straps sn re d b, bus s c q w r, address, expected write read select_n
  row_t rows [8] = '{{9'h01b, HIT, 3'h4}, {9'h049, HIT, 3'h2}, {9'h01f, HIT, 3'h1}, {9'h121, HIT, 3'h4},
                     {9'h19a, HIT, 3'h2}, {9'h140, MISS, 3'h7}, {9'h105, HIT, 3'h1}, {9'h010, HIT, 3'h0}};
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        sel, cyc, qn, wn, rn, lstb_n, din, re, sn, b32;
  logic        wr, rd, lsel_n, lqual_n, smode, romd;
  logic [15:1] addr, laddr;
  logic [1:0]  width, ew;
  int          err_total, cmp_count;
  always #25 clk = ~clk;
  host_cpu_model host (.clk_i(clk), .sel_o(sel), .cyc_o(cyc), .qual_n_o(qn), .wr_n_o(wn), .rd_n_o(rn),
    .ads_n_o(lstb_n), .addr_o(addr), .din_o(din), .rom_en_o(re), .sync_n_o(sn), .b32_o(b32));
  host_bus_strobe_decode DUT (.CLK_I(clk), .RST_N_I(rst_n), .SYNC_WRITE_READ_SEL_I(sel), .SYNC_CYCLE_I(cyc),
    .ADDR_QUALIFIER_N_I(qn), .WRITE_STROBE_N_I(wn), .READ_STROBE_N_I(rn), .ADDR_LATCH_STROBE_N_I(lstb_n),
    .ADDR_I(addr), .BASE_ADDR_I(BASE), .SERIAL_ROM_DATA_IN_I(din), .SERIAL_ROM_ENABLE_STRAP_I(re),
    .SYNC_MODE_STRAP_N_I(sn), .BUS32_VARIANT_I(b32), .WRITE_ACCESS_O(wr), .READ_ACCESS_O(rd),
    .LOCAL_SELECT_N_O(lsel_n), .LATCHED_ADDR_O(laddr), .LATCHED_QUAL_N_O(lqual_n), .BUS_WIDTH_O(width),
    .SYNC_MODE_O(smode), .ROM_SERIAL_DATA_O(romd));
  task chk(input string n, input logic [14:0] e, input logic [14:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task do_reset(input logic s, r, d, b);
    @(negedge clk);
    rst_n = 1'h0;
    host.strap(s, r, d, b);
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
  endtask
  initial begin
    #50000;
    err_total++;
    end_sim;
  end
  initial begin
    foreach (rows[i]) begin
      do_reset(rows[i][26], rows[i][25], rows[i][24], rows[i][23]);
      ew = rows[i][23] ? host_bus_pkg::WIDTH_32 : rows[i][25] ? host_bus_pkg::WIDTH_ROM_DEF :
           rows[i][24] ? host_bus_pkg::WIDTH_16 : host_bus_pkg::WIDTH_8;
      host.drive(rows[i][22], rows[i][21], rows[i][20], rows[i][19], rows[i][18], rows[i][17:3]);
      @(negedge clk);
      chk("width", ew, width);
      chk("sync_mode", !rows[i][26], smode);
      chk("write", rows[i][2], wr);
      chk("read", rows[i][1], rd);
      chk("select_n", rows[i][0], lsel_n);
      $display("row %0d done", i);
    end
    @(negedge clk);
    rst_n = 1'h0;
    host.drive(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, HIT);
    @(negedge clk);
    chk("rst_write", 1'h0, wr);
    chk("rst_read", 1'h0, rd);
    chk("rst_select_n", 1'h1, lsel_n);
    chk("rst_width", host_bus_pkg::WIDTH_8, width);
    chk("rst_sync_mode", host_bus_pkg::SYNC_RESET, smode);
    chk("rst_rom_data", 1'h0, romd);
    chk("rst_latched_addr", 15'h0, laddr);
    chk("rst_latched_qual_n", host_bus_pkg::QUAL_N_RESET, lqual_n);
    $display("reset test done");
    do_reset(1'h1, 1'h0, 1'h0, 1'h0);
    @(negedge clk);
    host.strap(1'h0, 1'h0, 1'h1, 1'h0);
    @(negedge clk);
    chk("width", host_bus_pkg::WIDTH_8, width);
    chk("sync_mode", 1'h0, smode);
    $display("strap hold test done");
    do_reset(1'h1, 1'h1, 1'h0, 1'h0);
    @(negedge clk);
    chk("rom_data", 1'h0, romd);
    host.strap(1'h1, 1'h1, 1'h1, 1'h0);
    @(negedge clk);
    chk("rom_data", 1'h1, romd);
    $display("rom data test done");
    host.latch(HIT, 1'h0);
    chk("latched_addr", HIT, laddr);
    chk("latched_qual_n", 1'h0, lqual_n);
    @(negedge clk);
    chk("latched_addr", HIT, laddr);
    $display("latch test done");
    end_sim;
  end
endmodule // host_bus_strobe_decode_bench
